//--- inc/atc_pkg.sv
// Purpose: shared constants and types for the acquisition trigger controller
// Assumes: 100 MHz clock, one acquisition sample per clock enable
// Notes:   all widths fixed; long counts are module parameters
`default_nettype none
package atc_pkg;
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          CLK_NS        = 10;
    localparam int          LVL_W         = 12;
    localparam int          REC_W         = 16;
    localparam int          TMR_W         = 32;
    localparam int          EVT_W         = 16;
    localparam int          PCT_W         = 7;
    localparam logic [6:0]  PCT_MAX       = 7'h64;
    localparam int          HOLDOFF_MIN_NS = 250;
    localparam int          HOLDOFF_MAX_S  = 12;
    localparam logic [TMR_W-1:0] HOLDOFF_MIN_CYC = TMR_W'((HOLDOFF_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TMR_W-1:0] HOLDOFF_MAX_CYC = TMR_W'(64'(HOLDOFF_MAX_S) * 64'(CLK_HZ));
    localparam logic [3:0]  DEF_HOLD_DIVS = 4'h5;

    typedef enum logic [1:0] {
        ATC_TYPE_EDGE  = 2'b00,
        ATC_TYPE_PULSE = 2'b01,
        ATC_TYPE_LOGIC = 2'b10,
        ATC_TYPE_VIDEO = 2'b11
    } atc_type_e;

    typedef enum logic [2:0] {
        ATC_CPL_DC    = 3'b000,
        ATC_CPL_AC    = 3'b001,
        ATC_CPL_LFREJ = 3'b010,
        ATC_CPL_HFREJ = 3'b011,
        ATC_CPL_NOISE = 3'b100
    } atc_cpl_e;

    typedef enum logic [2:0] {
        ATC_PULSE_GLITCH  = 3'b000,
        ATC_PULSE_RUNT    = 3'b001,
        ATC_PULSE_WIDTH   = 3'b010,
        ATC_PULSE_SLEW    = 3'b011,
        ATC_PULSE_TIMEOUT = 3'b100
    } atc_pulse_e;

    typedef enum logic [1:0] {
        ATC_LOGIC_PATTERN = 2'b00,
        ATC_LOGIC_STATE   = 2'b01,
        ATC_LOGIC_SETHOLD = 2'b10
    } atc_logic_e;

    typedef enum logic [2:0] {
        ATC_ST_STOP    = 3'b000,
        ATC_ST_ARM     = 3'b001,
        ATC_ST_READY   = 3'b010,
        ATC_ST_DLY     = 3'b011,
        ATC_ST_POST    = 3'b100,
        ATC_ST_HOLDOFF = 3'b101
    } atc_state_e;
endpackage
`default_nettype wire

//--- core/atc_edge_det.sv
// Purpose: level crossing detector on a sampled source
// Assumes: samples arrive on the same clock, qualified by i_smp_en
// Notes:   threshold takes effect on the very next sample
`default_nettype none
module atc_edge_det
    import atc_pkg::*;
(
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // sample in
    input  wire logic             i_smp_en,
    input  wire logic [LVL_W-1:0] i_sample,
    // setup
    input  wire logic [LVL_W-1:0] i_level,
    input  wire logic             i_falling,
    // event out
    output logic                  o_hit
);
    typedef struct packed {
        logic above;
        logic valid;
        logic hit;
    } atc_ed_s;

    atc_ed_s st_r;
    atc_ed_s st_nxt;
    logic    above_now;

    always_comb begin
        above_now = (i_sample >= i_level);
        st_nxt     = st_r;
        st_nxt.hit = 1'b0;
        if (i_smp_en) begin
            st_nxt.above = above_now;
            st_nxt.valid = 1'b1;
            // direction chosen by slope select
            if (st_r.valid) begin
                st_nxt.hit = i_falling ? (st_r.above && !above_now)
                                       : (!st_r.above && above_now); // [RULE_01] [RULE_11]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_hit = st_r.hit;
endmodule
`default_nettype wire

//--- core/atc_trigger_ctrl.sv
// Purpose: trigger qualification, mode, holdoff and record sequencing
// Assumes: pulse and logic qualifiers are external and deliver one-cycle hits
// Notes:   one record sample per i_smp_en pulse; long counts are parameters
//
// Overview of operation
// (RULE_01) edge trigger on threshold crossing in direction
// (RULE_02) pulse classes offered, main trigger only
// (RULE_03) logic pattern, state, setup-hold; main only
// (RULE_04) normal mode acquires only on trigger or force
// (RULE_05) auto mode forces trigger after timebase timeout
// (RULE_06) ignore triggers during record and holdoff
// (RULE_07) holdoff clamped between 250 ns and 12 s
// (RULE_08) default holdoff is five divisions of timebase
// (RULE_09) non-edge types forced to DC coupling
// (RULE_10) pretrigger share set by percentage of record
// (RULE_11) slope selects rising or falling crossing
// (RULE_12) delayed system: edge only, time and/or events
// (RULE_13) main level changes take effect at once
// (RULE_14) midpoint level sets half of measured peaks
// (RULE_15) delayed level held apart from main level
// (RULE_16) force starts record now, ignored when stopped
// (RULE_17) single sequence: one record per run request
// (RULE_18) single sequence unavailable in persistence mode
// (RULE_19) status lights show armed, ready, triggered
// (RULE_20) fill pretrigger continuously, then posttrigger
// (RULE_21) qualify only after pretrigger count is collected
// (RULE_22) timeout and holdoff are loadable down-counters
`default_nettype none
module atc_trigger_ctrl
    import atc_pkg::*;
#(
    parameter logic [TMR_W-1:0] P_HOLDOFF_MAX = HOLDOFF_MAX_CYC
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    // sample stream
    input  wire logic              i_smp_en,
    input  wire logic [LVL_W-1:0]  i_main_smp,
    input  wire logic [LVL_W-1:0]  i_dly_smp,
    // external qualifier hits
    input  wire logic              i_pulse_hit,
    input  wire logic              i_logic_hit,
    // trigger setup
    input  wire atc_type_e         i_trig_type,
    input  wire atc_pulse_e        i_pulse_class,
    input  wire atc_logic_e        i_logic_class,
    input  wire atc_cpl_e          i_coupling,
    input  wire logic              i_falling,
    input  wire logic              i_auto_mode,
    input  wire logic [LVL_W-1:0]  i_main_level,
    input  wire logic              i_main_level_wr,
    input  wire logic [LVL_W-1:0]  i_dly_level,
    input  wire logic              i_midpoint_level_request,
    // timing setup
    input  wire logic              i_default_holdoff,
    input  wire logic [TMR_W-1:0]  i_holdoff_cyc,
    input  wire logic [TMR_W-1:0]  i_div_cyc,
    input  wire logic [TMR_W-1:0]  i_auto_cyc,
    // record setup
    input  wire logic [REC_W-1:0]  i_rec_len,
    input  wire logic [PCT_W-1:0]  i_pre_pct,
    // delayed system
    input  wire logic              i_dly_en,
    input  wire logic              i_dly_by_time,
    input  wire logic              i_dly_by_events,
    input  wire logic [TMR_W-1:0]  i_dly_time_cyc,
    input  wire logic [EVT_W-1:0]  i_dly_evt_cnt,
    // front panel
    input  wire logic              i_force,
    input  wire logic              i_run_stop,
    input  wire logic              i_single_mode,
    input  wire logic              i_persist_mode,
    // status and sequencer
    output logic                   o_armed,
    output logic                   o_ready,
    output logic                   o_trigd,
    output logic                   o_trig_pulse,
    output logic                   o_forced,
    output logic                   o_rec_done,
    output logic [REC_W-1:0]       o_trig_pos,
    output atc_cpl_e               o_eff_coupling,
    output logic [LVL_W-1:0]       o_main_level,
    output logic [LVL_W-1:0]       o_dly_level,
    output logic                   o_pulse_sel,
    output logic                   o_logic_sel
);
    typedef struct packed {
        atc_state_e       state;
        logic             running;
        logic [REC_W-1:0] smp_cnt;
        logic [REC_W-1:0] pre_len;
        logic [TMR_W-1:0] hold_cnt;
        logic [TMR_W-1:0] auto_cnt;
        logic [TMR_W-1:0] dly_tcnt;
        logic [EVT_W-1:0] dly_ecnt;
        logic [LVL_W-1:0] main_lvl;
        logic [LVL_W-1:0] dly_lvl;
        logic [LVL_W-1:0] pk_max;
        logic [LVL_W-1:0] pk_min;
        atc_cpl_e         cpl;
        logic             pulse_sel;
        logic             logic_sel;
        logic             trig_p;
        logic             forced;
        logic             done_p;
    } atc_st_s;

    atc_st_s st_r;
    atc_st_s st_nxt;

    logic main_edge;
    logic dly_edge;

    // clamp a holdoff count into the legal window
    function automatic logic [TMR_W-1:0] clamp_hold(input logic [TMR_W-1:0] v);
        if (v < HOLDOFF_MIN_CYC) begin
            clamp_hold = HOLDOFF_MIN_CYC; // [RULE_07]
        end else if (v > P_HOLDOFF_MAX) begin
            clamp_hold = P_HOLDOFF_MAX; // [RULE_07]
        end else begin
            clamp_hold = v;
        end
    endfunction

    function automatic logic [TMR_W-1:0] dec_sat(input logic [TMR_W-1:0] v);
        dec_sat = (v == '0) ? '0 : v - TMR_W'(1);
    endfunction

    atc_edge_det u_main_edge (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_smp_en (i_smp_en),
        .i_sample (i_main_smp),
        .i_level  (st_r.main_lvl),
        .i_falling(i_falling),
        .o_hit    (main_edge)
    );

    // delayed system has only an edge qualifier, on its own level
    atc_edge_det u_dly_edge (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_smp_en (i_smp_en),
        .i_sample (i_dly_smp),
        .i_level  (st_r.dly_lvl),
        .i_falling(i_falling),
        .o_hit    (dly_edge)
    ); // [RULE_12] [RULE_15]

    logic             main_hit;
    logic [TMR_W-1:0] hold_load;
    logic [REC_W-1:0] pre_calc;
    logic             single_ok;
    logic             force_ok;
    logic             dly_met;

    always_comb begin
        main_hit  = 1'b0;
        hold_load = '0;
        pre_calc  = '0;
        single_ok = 1'b0;
        force_ok  = 1'b0;
        dly_met   = 1'b0;
        st_nxt    = st_r;
        st_nxt.trig_p = 1'b0;
        st_nxt.forced = 1'b0;
        st_nxt.done_p = 1'b0;

        // qualifier select; pulse and logic exist only on the main system
        case (i_trig_type)
            ATC_TYPE_EDGE:  main_hit = main_edge; // [RULE_01]
            ATC_TYPE_PULSE: main_hit = i_pulse_hit && (i_pulse_class <= ATC_PULSE_TIMEOUT); // [RULE_02]
            ATC_TYPE_LOGIC: main_hit = i_logic_hit && (i_logic_class <= ATC_LOGIC_SETHOLD); // [RULE_03]
            default:        main_hit = 1'b0;
        endcase
        st_nxt.pulse_sel = (i_trig_type == ATC_TYPE_PULSE); // [RULE_02]
        st_nxt.logic_sel = (i_trig_type == ATC_TYPE_LOGIC); // [RULE_03]

        // only edge may use filtered couplings
        st_nxt.cpl = (i_trig_type == ATC_TYPE_EDGE) ? i_coupling : ATC_CPL_DC; // [RULE_09]

        // holdoff: default tracks timebase each cycle, so scale changes apply
        hold_load = i_default_holdoff ? TMR_W'(i_div_cyc * TMR_W'(DEF_HOLD_DIVS)) // [RULE_08]
                                      : i_holdoff_cyc;
        hold_load = clamp_hold(hold_load); // [RULE_07]

        // pretrigger share; percentages above 100 are saturated
        pre_calc = REC_W'((32'(i_rec_len) * 32'((i_pre_pct > PCT_MAX) ? PCT_MAX : i_pre_pct))
                          / 32'(PCT_MAX)); // [RULE_10]

        // peak tracking for the midpoint request
        if (i_smp_en) begin
            if (i_main_smp > st_r.pk_max) st_nxt.pk_max = i_main_smp;
            if (i_main_smp < st_r.pk_min) st_nxt.pk_min = i_main_smp;
        end
        if (i_main_level_wr) begin
            st_nxt.main_lvl = i_main_level; // [RULE_13]
        end else if (i_midpoint_level_request &&
                     (i_trig_type == ATC_TYPE_EDGE ||
                      (i_trig_type == ATC_TYPE_PULSE &&
                       (i_pulse_class == ATC_PULSE_GLITCH || i_pulse_class == ATC_PULSE_WIDTH)))) begin
            st_nxt.main_lvl = LVL_W'((13'(st_r.pk_max) + 13'(st_r.pk_min)) >> 1); // [RULE_14]
        end
        st_nxt.dly_lvl = i_dly_level; // [RULE_15]

        single_ok = i_single_mode && !i_persist_mode; // [RULE_18]
        force_ok  = i_force && st_r.running; // [RULE_16]

        // run/stop toggles; in single mode without persistence every run arms one sequence
        if (i_run_stop) begin
            st_nxt.running = !st_r.running; // [RULE_17]
        end

        // auto timer runs from run start and from each qualified trigger, not from a forced one
        if (st_r.auto_cnt != '0) begin
            st_nxt.auto_cnt = dec_sat(st_r.auto_cnt); // [RULE_22]
        end

        case (st_r.state)
            ATC_ST_STOP: begin
                st_nxt.smp_cnt = '0;
                if (st_r.running) begin
                    st_nxt.pre_len  = pre_calc; // [RULE_10]
                    st_nxt.auto_cnt = i_auto_cyc; // [RULE_05]
                    st_nxt.state    = ATC_ST_ARM;
                end
            end
            ATC_ST_ARM: begin
                // continuous pretrigger fill
                if (i_smp_en && st_r.smp_cnt < st_r.pre_len) begin
                    st_nxt.smp_cnt = st_r.smp_cnt + REC_W'(1); // [RULE_20]
                end
                if (force_ok) begin
                    st_nxt.forced = 1'b1; // [RULE_16]
                    st_nxt.trig_p = 1'b1;
                    st_nxt.state  = ATC_ST_POST;
                end else if (st_r.smp_cnt >= st_r.pre_len) begin
                    st_nxt.state = ATC_ST_READY; // [RULE_21]
                end
            end
            ATC_ST_READY: begin
                if (force_ok || (i_auto_mode && st_r.auto_cnt == '0)) begin
                    st_nxt.forced = 1'b1; // [RULE_05] [RULE_16]
                    st_nxt.trig_p = 1'b1;
                    st_nxt.state  = ATC_ST_POST;
                end else if (main_hit) begin
                    st_nxt.trig_p   = 1'b1; // [RULE_04]
                    st_nxt.auto_cnt = i_auto_cyc; // [RULE_05]
                    st_nxt.dly_tcnt = i_dly_time_cyc;
                    st_nxt.dly_ecnt = i_dly_evt_cnt;
                    st_nxt.state    = i_dly_en ? ATC_ST_DLY : ATC_ST_POST;
                end
                if (!st_r.running) begin
                    st_nxt.state = ATC_ST_STOP;
                end
            end
            ATC_ST_DLY: begin
                // wait for time, events or both after the main trigger
                if (st_r.dly_tcnt != '0) begin
                    st_nxt.dly_tcnt = st_r.dly_tcnt - TMR_W'(1);
                end
                if (dly_edge && st_r.dly_ecnt != '0) begin
                    st_nxt.dly_ecnt = st_r.dly_ecnt - EVT_W'(1);
                end
                dly_met = (!i_dly_by_time || st_r.dly_tcnt == '0) &&
                          (!i_dly_by_events || st_r.dly_ecnt == '0); // [RULE_12]
                if (dly_met || force_ok) begin
                    st_nxt.state = ATC_ST_POST;
                end
            end
            ATC_ST_POST: begin
                // triggers ignored here
                if (i_smp_en) begin
                    st_nxt.smp_cnt = st_r.smp_cnt + REC_W'(1); // [RULE_06] [RULE_20]
                end
                if (st_r.smp_cnt >= i_rec_len) begin
                    st_nxt.done_p   = 1'b1;
                    st_nxt.hold_cnt = hold_load; // [RULE_22]
                    st_nxt.state    = ATC_ST_HOLDOFF;
                    if (single_ok) begin
                        st_nxt.running = 1'b0; // [RULE_17]
                    end
                end
            end
            ATC_ST_HOLDOFF: begin
                st_nxt.hold_cnt = dec_sat(st_r.hold_cnt); // [RULE_06] [RULE_22]
                if (st_r.hold_cnt <= TMR_W'(1)) begin
                    st_nxt.smp_cnt = '0;
                    st_nxt.pre_len = pre_calc;
                    st_nxt.state   = st_r.running ? ATC_ST_ARM : ATC_ST_STOP;
                end
            end
            default: st_nxt.state = ATC_ST_STOP;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_r        <= '0;
            st_r.pk_min <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // status lights; triggered plus ready means waiting for delayed event
    assign o_armed        = (st_r.state == ATC_ST_ARM); // [RULE_19]
    assign o_ready        = (st_r.state == ATC_ST_READY) || (st_r.state == ATC_ST_DLY); // [RULE_19]
    assign o_trigd        = (st_r.state == ATC_ST_POST) || (st_r.state == ATC_ST_DLY); // [RULE_19]
    assign o_trig_pulse   = st_r.trig_p;
    assign o_forced       = st_r.forced;
    assign o_rec_done     = st_r.done_p;
    assign o_trig_pos     = st_r.pre_len;
    assign o_eff_coupling = st_r.cpl;
    assign o_main_level   = st_r.main_lvl;
    assign o_dly_level    = st_r.dly_lvl;
    assign o_pulse_sel    = st_r.pulse_sel;
    assign o_logic_sel    = st_r.logic_sel;
endmodule
`default_nettype wire

//--- testbench/atc_trig_asserts.sv
// Purpose: port-level checks for the trigger controller
// Assumes: bound to atc_trigger_ctrl, one clock domain
// Notes:   holdoff floor of 25 cycles covers the eight quiet cycles
`default_nettype none
module atc_trig_asserts
    import atc_pkg::*;
(
    // clock and reset
    input wire logic             i_clk,
    input wire logic             i_nrst,
    // watched inputs
    input wire logic             i_force,
    input wire atc_type_e        i_trig_type,
    input wire atc_cpl_e         i_coupling,
    input wire logic [LVL_W-1:0] i_main_level,
    input wire logic             i_main_level_wr,
    input wire logic             i_midpoint_level_request,
    input wire logic [LVL_W-1:0] i_dly_level,
    // watched outputs
    input wire logic             o_armed,
    input wire logic             o_ready,
    input wire logic             o_trigd,
    input wire logic             o_trig_pulse,
    input wire logic             o_forced,
    input wire logic             o_rec_done,
    input wire atc_cpl_e         o_eff_coupling,
    input wire logic [LVL_W-1:0] o_main_level,
    input wire logic [LVL_W-1:0] o_dly_level
);
    wire logic live = o_armed | o_ready | o_trigd;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_quiet;
        !o_ready && !o_trig_pulse;
    endsequence
    sequence s_force_rdy;
        o_ready && i_force;
    endsequence
    a_status_legal: assert property (!(o_armed && (o_ready || o_trigd)))
        else $error("armed lit with ready or triggered");
    a_force_start: assert property (s_force_rdy |-> ##[1:3] o_trigd)
        else $error("force did not start the record");
    a_force_live: assert property (o_forced |-> $past(live))
        else $error("force acted while stopped");
    a_trig_from_ready: assert property (o_trig_pulse && !o_forced |-> $past(o_ready))
        else $error("trigger taken outside ready");
    a_holdoff_quiet: assert property (o_rec_done |=> s_quiet [*8])
        else $error("trigger accepted during holdoff");
    a_cpl_dc_only: assert property ((i_trig_type != ATC_TYPE_EDGE) && $stable(i_trig_type) && $past(i_nrst)
        |-> o_eff_coupling == ATC_CPL_DC) else $error("non-edge coupling not DC");
    a_cpl_edge_any: assert property ((i_trig_type == ATC_TYPE_EDGE) && $stable(i_trig_type)
        && $stable(i_coupling) && $past(i_nrst) |-> o_eff_coupling == i_coupling)
        else $error("edge coupling not passed");
    a_level_write: assert property ($past(i_main_level_wr) && !$past(i_midpoint_level_request)
        && $past(i_nrst) |-> o_main_level == $past(i_main_level)) else $error("main level not taken");
    a_dly_level: assert property ($past(i_nrst) |-> o_dly_level == $past(i_dly_level))
        else $error("delayed level not held");
endmodule
bind atc_trigger_ctrl atc_trig_asserts u_chk (.i_clk, .i_nrst, .i_force, .i_trig_type, .i_coupling,
    .i_main_level, .i_main_level_wr, .i_midpoint_level_request, .i_dly_level, .o_armed, .o_ready,
    .o_trigd, .o_trig_pulse, .o_forced, .o_rec_done, .o_eff_coupling, .o_main_level, .o_dly_level);
`default_nettype wire

//--- testbench/atc_src_model.sv
// Purpose: trigger source and sample stream stand-in
// Assumes: one sample every second clock
// Notes:   data bus shows inverted value between samples
`default_nettype none
module atc_src_model
    import atc_pkg::*;
(
    // clock
    input  wire logic             i_clk,
    // bench commands
    input  wire logic [LVL_W-1:0] i_lvl,
    input  wire logic             i_hit_req,
    // toward the controller
    output logic                  o_smp_en,
    output logic [LVL_W-1:0]      o_smp,
    output logic [LVL_W-1:0]      o_dly_smp,
    output logic                  o_pulse_hit,
    output logic                  o_logic_hit
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_smp_en = 1'b0;
    // acquisition never pauses, so the pretrigger share keeps filling
    always @(negedge i_clk) o_smp_en <= ~o_smp_en;
    // junk between samples so stale data cannot pass for a sample
    assign o_smp = o_smp_en ? i_lvl : ~i_lvl;
    assign o_dly_smp = o_smp;
    assign o_pulse_hit = i_hit_req;
    assign o_logic_hit = i_hit_req;
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: sequence-level test of the trigger controller
// Assumes: holdoff ceiling shortened to 1000 cycles
// Notes:   holdoff figures allow two cycles of pipeline slack
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import atc_pkg::*;
    logic             i_clk, i_nrst, i_smp_en, i_pulse_hit, i_logic_hit, i_falling, i_auto_mode;
    logic             i_main_level_wr, i_midpoint_level_request, i_default_holdoff, i_dly_en;
    logic             i_dly_by_time, i_dly_by_events, i_force, i_run_stop, i_single_mode, i_persist_mode;
    logic             o_armed, o_ready, o_trigd, o_trig_pulse, o_forced, o_rec_done, hit_req, saw_dly;
    logic             o_pulse_sel, o_logic_sel;
    logic [LVL_W-1:0] i_main_smp, i_dly_smp, i_main_level, i_dly_level, lvl, o_main_level, o_dly_level;
    logic [TMR_W-1:0] i_holdoff_cyc, i_div_cyc, i_auto_cyc, i_dly_time_cyc;
    logic [REC_W-1:0] i_rec_len, o_trig_pos;
    logic [PCT_W-1:0] i_pre_pct;
    logic [EVT_W-1:0] i_dly_evt_cnt;
    atc_type_e        i_trig_type;
    atc_pulse_e       i_pulse_class;
    atc_logic_e       i_logic_class;
    atc_cpl_e         i_coupling, o_eff_coupling;
    int               n_errors, checks_done, h, n, c;
    atc_src_model u_src (.i_clk, .i_lvl(lvl), .i_hit_req(hit_req), .o_smp_en(i_smp_en), .o_smp(i_main_smp),
        .o_dly_smp(i_dly_smp), .o_pulse_hit(i_pulse_hit), .o_logic_hit(i_logic_hit));
    atc_trigger_ctrl #(.P_HOLDOFF_MAX(32'h0000_03E8)) DUT (.*);
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic tick(input int k = 1);
        repeat (k) @(negedge i_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            n_errors++;
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    function automatic logic sig(input int k);
        case (k)
            1: return o_ready;
            3: return o_rec_done;
            default: return o_forced;
        endcase
    endfunction
    task automatic wait_sig(input int k, input int lim);
        c = 0;
        while (sig(k) !== 1'b1 && c < lim) begin
            tick();
            c++;
            if (o_ready === 1'b1 && o_trigd === 1'b1) saw_dly = 1'b1;
        end
        if (c >= lim) chk("wait", 1, 0);
    endtask
    // 0 force, 1 run/stop, 2 qualifier hit, 3 level write, 4 midpoint
    task automatic pulse(input int k);
        {i_force, i_run_stop, hit_req, i_main_level_wr, i_midpoint_level_request} = 5'h10 >> k;
        tick();
        {i_force, i_run_stop, hit_req, i_main_level_wr, i_midpoint_level_request} = 5'h00;
        tick();
    endtask
    // kind above 4 triggers by moving the source level to v
    task automatic run_rec(input int kind, input logic [LVL_W-1:0] v);
        wait_sig(1, 300);
        if (kind > 4) lvl = v;
        else pulse(kind);
        wait_sig(3, 300);
        h = 0;
        while (o_armed !== 1'b1 && h < 1100) begin
            tick();
            h++;
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        {i_force, i_run_stop, hit_req, i_main_level_wr, i_midpoint_level_request} = 5'h00;
        i_nrst = 1'b0;
        lvl = 12'h100;
        saw_dly = 1'b0;
        {i_falling, i_auto_mode, i_default_holdoff, i_dly_en, i_single_mode, i_persist_mode} = 6'h00;
        {i_dly_by_time, i_dly_by_events} = 2'h2;
        i_trig_type = ATC_TYPE_EDGE;
        i_pulse_class = ATC_PULSE_GLITCH;
        i_logic_class = ATC_LOGIC_PATTERN;
        i_coupling = ATC_CPL_AC;
        i_main_level = 12'h800;
        i_dly_level = 12'h456;
        i_holdoff_cyc = 32'h28;
        i_div_cyc = 32'hA;
        i_auto_cyc = 32'h3C;
        i_dly_time_cyc = 32'hA;
        i_dly_evt_cnt = 16'h2;
        i_rec_len = 16'h14;
        i_pre_pct = 7'h32;
        tick(8);
        i_nrst = 1'b1;
        chk("status", 3'h0, {o_armed, o_ready, o_trigd});
        pulse(0);
        tick(3);
        chk("force_stopped", 1'h0, o_trigd);
        pulse(3);
        chk("main_lvl", 12'h800, o_main_level);
        pulse(1);
        chk("armed", 1'h1, o_armed);
        n = 0;
        c = 0;
        while (o_ready !== 1'b1 && c < 200) begin
            tick();
            c++;
            n += (i_smp_en === 1'b1);
        end
        rng("pre_cnt", 9, 11, n);
        chk("trig_pos", 16'hA, o_trig_pos);
        tick(60);
        chk("normal_idle", 2'h2, {o_ready, o_trigd});
        run_rec(9, 12'hF00);
        rng("holdoff", 38, 42, h);
        i_falling = 1'b1;
        lvl = 12'h100;
        wait_sig(1, 300);
        lvl = 12'hF00;
        tick(20);
        chk("slope", 2'h2, {o_ready, o_trigd});
        run_rec(9, 12'h100);
        i_falling = 1'b0;
        i_holdoff_cyc = 32'h3;
        run_rec(0, 12'h0);
        rng("hold_min", 23, 27, h);
        i_holdoff_cyc = 32'h4000;
        run_rec(0, 12'h0);
        rng("hold_max", 998, 1002, h);
        i_default_holdoff = 1'b1;
        run_rec(0, 12'h0);
        rng("hold_def", 48, 52, h);
        i_div_cyc = 32'h14;
        run_rec(0, 12'h0);
        rng("hold_def2", 98, 102, h);
        {i_default_holdoff, i_holdoff_cyc} = {1'b0, 32'h28};
        i_trig_type = ATC_TYPE_PULSE;
        run_rec(2, 12'h0);
        i_trig_type = ATC_TYPE_LOGIC;
        run_rec(2, 12'h0);
        i_trig_type = ATC_TYPE_PULSE;
        i_dly_en = 1'b1;
        saw_dly = 1'b0;
        run_rec(2, 12'h0);
        chk("dly_wait", 1'h1, saw_dly);
        i_dly_en = 1'b0;
        for (int k = 0; k < 5; k++) begin
            i_coupling = atc_cpl_e'(k);
            i_trig_type = ATC_TYPE_EDGE;
            tick(2);
            chk("cpl_edge", 32'(k), {o_pulse_sel, o_logic_sel, o_eff_coupling});
            i_trig_type = ATC_TYPE_PULSE;
            tick(2);
            chk("cpl_dc", {2'h2, ATC_CPL_DC}, {o_pulse_sel, o_logic_sel, o_eff_coupling});
        end
        i_dly_level = 12'h3A5;
        i_main_level = 12'h123;
        tick(2);
        chk("dly_lvl", 12'h3A5, o_dly_level);
        chk("main_keep", 12'h800, o_main_level);
        pulse(3);
        i_trig_type = ATC_TYPE_LOGIC;
        pulse(4);
        chk("mid_logic", 14'h1123, {o_pulse_sel, o_logic_sel, o_main_level});
        i_trig_type = ATC_TYPE_PULSE;
        pulse(4);
        chk("mid_glitch", 12'h800, o_main_level);
        i_trig_type = ATC_TYPE_EDGE;
        i_auto_mode = 1'b1;
        wait_sig(4, 400);
        i_auto_mode = 1'b0;
        {i_single_mode, i_persist_mode} = 2'h3;
        run_rec(0, 12'h0);
        rng("persist", 38, 42, h);
        i_persist_mode = 1'b0;
        run_rec(0, 12'h0);
        chk("single_stop", 3'h0, {o_armed, o_ready, o_trigd});
        pulse(1);
        run_rec(0, 12'h0);
        chk("single_again", 3'h0, {o_armed, o_ready, o_trigd});
        give_verdict();
    end
endmodule
`default_nettype wire
